//--- acrs_pkg.sv
// Package holding register map, field positions and carrier types for the config slice
package acrs_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    // =========================================================
    // Register offsets
    localparam logic [7:0] PATTERN_B_SPLIT_WORD_OFF  = 8'h1a;
    localparam logic [7:0] PATTERN_B_ONE_UPPER_OFF   = 8'h1b;
    localparam logic [7:0] RESULT_TAG_BITS_OFF       = 8'h1c;
    localparam logic [7:0] CALIB_AND_INIT_KEY_OFF    = 8'h33;
    localparam logic [7:0] LANE_AVG_POWERDOWN_OFF    = 8'hc0;
    localparam logic [7:0] REFERENCE_RATE_SELECT_OFF = 8'hc1;

    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] READ_NONE = 16'h0000;
    // Low sixteen bits of channel B pattern zero live in the neighbouring bank
    localparam logic [15:0] PAT_ZERO_LOW_FILL = 16'h0000;

    // =========================================================
    // Field positions
    localparam int unsigned GAIN_HI_BIT   = 13;
    localparam int unsigned GAIN_LO_BIT   = 6;
    localparam int unsigned INIT_KEY_LSB  = 4;
    localparam int unsigned LANE_CLK_BIT  = 12;
    localparam int unsigned AVG_LSB       = 10;
    localparam int unsigned PD_LSB        = 0;
    localparam int unsigned REF_DIS_BIT   = 11;
    localparam int unsigned DATA_RATE_BIT = 8;
    localparam logic [1:0]  INIT_KEY_OPEN = 2'h3;

    // Pattern-mode codes for channel B test output
    localparam logic [1:0] PAT_FIXED0  = 2'h0;
    localparam logic [1:0] PAT_FIXED0B = 2'h1;
    localparam logic [1:0] PAT_RAMP    = 2'h2;
    localparam logic [1:0] PAT_ALT     = 2'h3;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } acrs_req_s;

    typedef struct packed {
        logic [23:0] pattern_zero_chan_b;
        logic [23:0] pattern_one_chan_b;
        logic [7:0]  tag_chan_a;
        logic [7:0]  tag_chan_b;
        logic        gain_cal_on;
        logic        init_unlocked;
        logic        lane_clock_config;
        logic [1:0]  averaging_setup;
        logic        chan_a_powered_down;
        logic        chan_b_powered_down;
        logic        reference_disable;
        logic        single_data_rate;
    } acrs_cfg_s;

endpackage

//--- acrs_regs.sv
// Configuration register slice: pattern, tag, calibration, lane, power and rate controls
`timescale 1ns/10ps
// =========================================================
module acrs_regs #(
    parameter int unsigned ADDR_W = acrs_pkg::ADDR_W,
    parameter int unsigned DATA_W = acrs_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // Register port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    // Pattern mode from the neighbouring register bank
    input  wire logic [1:0]          pattern_select_chan_b,
    // Decoded configuration
    output acrs_pkg::acrs_cfg_s      cfg,
    output logic                     pat_use_ramp,
    output logic                     pat_alternate
);

    logic [DATA_W-1:0] split_q, one_up_q, tag_q, calib_q, lane_q, refr_q;

    // =========================================================
    // Register storage
    // reset and store
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            split_q  <= acrs_pkg::REG_RESET;
            one_up_q <= acrs_pkg::REG_RESET;
            tag_q    <= acrs_pkg::REG_RESET;
            calib_q  <= acrs_pkg::REG_RESET;
            lane_q   <= acrs_pkg::REG_RESET;
            refr_q   <= acrs_pkg::REG_RESET;
        end else if (reg_wr) begin
            // Reserved bits are stored as written; keeping them zero is software's job
            unique case (reg_addr)
                acrs_pkg::PATTERN_B_SPLIT_WORD_OFF:  split_q  <= reg_wdata;
                acrs_pkg::PATTERN_B_ONE_UPPER_OFF:   one_up_q <= reg_wdata;
                acrs_pkg::RESULT_TAG_BITS_OFF:       tag_q    <= reg_wdata;
                acrs_pkg::CALIB_AND_INIT_KEY_OFF:    calib_q  <= reg_wdata;
                acrs_pkg::LANE_AVG_POWERDOWN_OFF:    lane_q   <= reg_wdata;
                acrs_pkg::REFERENCE_RATE_SELECT_OFF: refr_q   <= reg_wdata;
                default: ;
            endcase
        end
    end

    // =========================================================
    // Read path, data in the cycle after the strobe
    // read back
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= acrs_pkg::READ_NONE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                acrs_pkg::PATTERN_B_SPLIT_WORD_OFF:  reg_rdata <= split_q;
                acrs_pkg::PATTERN_B_ONE_UPPER_OFF:   reg_rdata <= one_up_q;
                acrs_pkg::RESULT_TAG_BITS_OFF:       reg_rdata <= tag_q;
                acrs_pkg::CALIB_AND_INIT_KEY_OFF:    reg_rdata <= calib_q;
                acrs_pkg::LANE_AVG_POWERDOWN_OFF:    reg_rdata <= lane_q;
                acrs_pkg::REFERENCE_RATE_SELECT_OFF: reg_rdata <= refr_q;
                default:                             reg_rdata <= acrs_pkg::READ_NONE;
            endcase
        end else begin
            reg_rdata <= acrs_pkg::READ_NONE;
        end
    end

    // =========================================================
    // Field decode
    always_comb begin
        cfg.pattern_one_chan_b[7:0]   = split_q[15:8];
        cfg.pattern_one_chan_b[23:8]  = one_up_q;
        // pattern zero top byte; lower bits live in the previous register
        cfg.pattern_zero_chan_b       = {split_q[7:0], acrs_pkg::PAT_ZERO_LOW_FILL};
        cfg.tag_chan_b                = tag_q[15:8];
        cfg.tag_chan_a                = tag_q[7:0];
        // either global enable turns calibration on
        cfg.gain_cal_on               = calib_q[acrs_pkg::GAIN_HI_BIT] | calib_q[acrs_pkg::GAIN_LO_BIT];
        // init key open only on exact code
        cfg.init_unlocked             = calib_q[acrs_pkg::INIT_KEY_LSB +: 2] == acrs_pkg::INIT_KEY_OPEN;
        cfg.lane_clock_config         = lane_q[acrs_pkg::LANE_CLK_BIT];
        cfg.averaging_setup           = lane_q[acrs_pkg::AVG_LSB +: 2];
        cfg.chan_a_powered_down       = lane_q[acrs_pkg::PD_LSB];
        cfg.chan_b_powered_down       = lane_q[acrs_pkg::PD_LSB + 1];
        cfg.reference_disable         = refr_q[acrs_pkg::REF_DIS_BIT];
        cfg.single_data_rate          = refr_q[acrs_pkg::DATA_RATE_BIT];
    end

    always_comb begin
        pat_use_ramp  = 1'b0;
        pat_alternate = 1'b0;
        unique case (pattern_select_chan_b)
            acrs_pkg::PAT_FIXED0, acrs_pkg::PAT_FIXED0B: ;
            acrs_pkg::PAT_RAMP: pat_use_ramp  = 1'b1;
            acrs_pkg::PAT_ALT:  pat_alternate = 1'b1;
        endcase
    end

    // =========================================================
    // Checks
    // Per-register write strobes shared by the checks below
    logic wr_split, wr_one_up, wr_tag, wr_calib, wr_lane, wr_refr, addr_mapped;
    assign wr_split    = reg_wr && reg_addr == acrs_pkg::PATTERN_B_SPLIT_WORD_OFF;
    assign wr_one_up   = reg_wr && reg_addr == acrs_pkg::PATTERN_B_ONE_UPPER_OFF;
    assign wr_tag      = reg_wr && reg_addr == acrs_pkg::RESULT_TAG_BITS_OFF;
    assign wr_calib    = reg_wr && reg_addr == acrs_pkg::CALIB_AND_INIT_KEY_OFF;
    assign wr_lane     = reg_wr && reg_addr == acrs_pkg::LANE_AVG_POWERDOWN_OFF;
    assign wr_refr     = reg_wr && reg_addr == acrs_pkg::REFERENCE_RATE_SELECT_OFF;
    assign addr_mapped = reg_addr inside {acrs_pkg::PATTERN_B_SPLIT_WORD_OFF, acrs_pkg::PATTERN_B_ONE_UPPER_OFF,
                                          acrs_pkg::RESULT_TAG_BITS_OFF, acrs_pkg::CALIB_AND_INIT_KEY_OFF,
                                          acrs_pkg::LANE_AVG_POWERDOWN_OFF, acrs_pkg::REFERENCE_RATE_SELECT_OFF};

    // =========================================================
    // Pattern words
    // pattern one low byte
    split_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_split
        |=> cfg.pattern_one_chan_b[7:0] == $past(reg_wdata[15:8])) else $error("pattern one low byte wrong");
    zero_top_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_split
        |=> cfg.pattern_zero_chan_b[23:16] == $past(reg_wdata[7:0])) else $error("pattern zero top byte wrong");
    zero_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg.pattern_zero_chan_b[15:0] == acrs_pkg::PAT_ZERO_LOW_FILL)
        else $error("pattern zero low bits not clear");
    one_upper_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_one_up
        |=> cfg.pattern_one_chan_b[23:8] == $past(reg_wdata)) else $error("pattern one upper wrong");

    // =========================================================
    // Tags
    // channel B tag
    tag_b_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_tag
        |=> cfg.tag_chan_b == $past(reg_wdata[15:8])) else $error("channel B tag wrong");
    tag_a_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_tag
        |=> cfg.tag_chan_a == $past(reg_wdata[7:0])) else $error("channel A tag wrong");

    // =========================================================
    // Calibration and key
    // high enable
    gain_hi_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_calib && reg_wdata[acrs_pkg::GAIN_HI_BIT]
        |=> cfg.gain_cal_on) else $error("gain cal high enable ignored");
    gain_lo_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_calib && reg_wdata[acrs_pkg::GAIN_LO_BIT]
        |=> cfg.gain_cal_on) else $error("gain cal low enable ignored");
    gain_off_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_calib && !reg_wdata[acrs_pkg::GAIN_HI_BIT] && !reg_wdata[acrs_pkg::GAIN_LO_BIT]
        |=> !cfg.gain_cal_on) else $error("gain cal stays on");
    init_key_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_calib
        |=> cfg.init_unlocked == ($past(reg_wdata[acrs_pkg::INIT_KEY_LSB +: 2]) == acrs_pkg::INIT_KEY_OPEN))
        else $error("init key decode wrong");

    // =========================================================
    // Lane and power
    // lane clock field
    lane_clk_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_lane
        |=> cfg.lane_clock_config == $past(reg_wdata[acrs_pkg::LANE_CLK_BIT])) else $error("lane clock wrong");
    avg_setup_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_lane
        |=> cfg.averaging_setup == $past(reg_wdata[acrs_pkg::AVG_LSB +: 2])) else $error("averaging wrong");
    pd_chan_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_lane
        |=> {cfg.chan_b_powered_down, cfg.chan_a_powered_down} == $past(reg_wdata[acrs_pkg::PD_LSB +: 2]))
        else $error("power-down decode wrong");

    // =========================================================
    // Rate and reference
    // rate and reference
    rate_ref_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_refr
        |=> cfg.single_data_rate == $past(reg_wdata[acrs_pkg::DATA_RATE_BIT])
            && cfg.reference_disable == $past(reg_wdata[acrs_pkg::REF_DIS_BIT]))
        else $error("rate or reference select wrong");

    // =========================================================
    // Pattern mode
    // ramp decode
    pat_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
        !(pat_use_ramp && pat_alternate) && (pat_use_ramp == (pattern_select_chan_b == acrs_pkg::PAT_RAMP)))
        else $error("pattern mode decode wrong");
    alt_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
        pat_alternate == (pattern_select_chan_b == acrs_pkg::PAT_ALT))
        else $error("alternate mode decode wrong");

    // =========================================================
    // Read port
    // readback per register
    readback_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_lane ##1 reg_rd && reg_addr == acrs_pkg::LANE_AVG_POWERDOWN_OFF
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback mismatch");
    split_rb_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_split ##1 reg_rd && reg_addr == acrs_pkg::PATTERN_B_SPLIT_WORD_OFF
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("split word readback mismatch");
    one_rb_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_one_up ##1 reg_rd && reg_addr == acrs_pkg::PATTERN_B_ONE_UPPER_OFF
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("upper word readback mismatch");
    tag_rb_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_tag ##1 reg_rd && reg_addr == acrs_pkg::RESULT_TAG_BITS_OFF
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("tag readback mismatch");
    calib_rb_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_calib ##1 reg_rd && reg_addr == acrs_pkg::CALIB_AND_INIT_KEY_OFF
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("calibration readback mismatch");
    refr_rb_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_refr ##1 reg_rd && reg_addr == acrs_pkg::REFERENCE_RATE_SELECT_OFF
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("rate readback mismatch");
    rdata_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
        !reg_rd
        |=> reg_rdata == acrs_pkg::READ_NONE) else $error("read data outside its cycle");
    unmapped_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && !addr_mapped
        |=> reg_rdata == acrs_pkg::READ_NONE) else $error("unmapped read not zero");
    reset_zero_a: assert property (@(posedge sys_clk) $past(rst) |-> reg_rdata == acrs_pkg::READ_NONE
        && !cfg.gain_cal_on) else $error("not zero after reset");
    reset_cfg_a: assert property (@(posedge sys_clk)
        $past(rst) |-> cfg == '0) else $error("fields not zero after reset");

    // =========================================================
    // Hold between writes
    // unmapped write ignored
    unmapped_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && !addr_mapped
        |=> $stable(cfg)) else $error("unmapped write changed a field");
    split_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_split
        |=> $stable(cfg.pattern_one_chan_b[7:0]) && $stable(cfg.pattern_zero_chan_b)) else $error("split word drifted");
    one_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_one_up
        |=> $stable(cfg.pattern_one_chan_b[23:8])) else $error("upper word drifted");
    tag_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_tag
        |=> $stable(cfg.tag_chan_a) && $stable(cfg.tag_chan_b)) else $error("tags drifted");
    calib_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_calib
        |=> $stable(cfg.gain_cal_on) && $stable(cfg.init_unlocked)) else $error("calibration drifted");
    lane_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_lane
        |=> $stable({cfg.lane_clock_config, cfg.averaging_setup, cfg.chan_b_powered_down, cfg.chan_a_powered_down}))
        else $error("lane or power drifted");
    refr_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_refr
        |=> $stable(cfg.single_data_rate) && $stable(cfg.reference_disable)) else $error("rate drifted");

    unlock_c: cover property (@(posedge sys_clk) disable iff (rst) !cfg.init_unlocked ##1 cfg.init_unlocked);
    both_pd_c: cover property (@(posedge sys_clk) disable iff (rst) cfg.chan_a_powered_down && cfg.chan_b_powered_down);
    sdr_c: cover property (@(posedge sys_clk) disable iff (rst) cfg.single_data_rate && cfg.reference_disable);
    wr_rd_c: cover property (@(posedge sys_clk) disable iff (rst) reg_wr ##1 reg_rd);

endmodule

//--- tb.sv
// Self-checking testbench for the configuration register slice
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
    typedef struct {logic [7:0] a; logic [15:0] d;} acrs_tb_row_s;
    logic                 sys_clk = 1'b0;
    logic                 rst = 1'b1;
    logic [7:0]           reg_addr = 8'h00;
    logic [15:0]          reg_wdata = 16'h0000;
    logic                 reg_wr = 1'b0;
    logic                 reg_rd = 1'b0;
    logic [15:0]          reg_rdata;
    logic [1:0]           pattern_select_chan_b = 2'h0;
    acrs_pkg::acrs_cfg_s  cfg;
    logic                 pat_use_ramp;
    logic                 pat_alternate;
    int                   mismatches = 0;
    int                   checked = 0;
    // reserved kept zero
    // Rows set every field except chan_a_powered_down and GAIN_LO_BIT, so cross-talk between registers shows up
    acrs_tb_row_s rows [6] = '{'{8'h1a, 16'ha55a}, '{8'h1b, 16'h1234}, '{8'h1c, 16'hc37e},
                               '{8'h33, 16'h2030}, '{8'hc0, 16'h1402}, '{8'hc1, 16'h0900}};

    always #4 sys_clk = ~sys_clk;

    acrs_regs dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
                   .pattern_select_chan_b(pattern_select_chan_b), .cfg(cfg),
                   .pat_use_ramp(pat_use_ramp), .pat_alternate(pat_alternate));

    // =========================================================
    // Bus tasks: a write leaves its strobe up so a read may follow with no gap
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task automatic idle();
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        give_verdict();
    end

    // =========================================================
    // Main sequence
    initial begin
        logic [15:0] q;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        `CHK(cfg, acrs_pkg::acrs_cfg_s'(0))
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, q);
            `CHK(q, rows[i].d)
            idle();
            `CHK(reg_rdata, 16'h0000)
        end
        `CHK(cfg.pattern_one_chan_b, 24'h12_34a5)
        `CHK(cfg.pattern_zero_chan_b[23:16], 8'h5a)
        `CHK(cfg.tag_chan_b, 8'hc3)
        `CHK(cfg.tag_chan_a, 8'h7e)
        `CHK({cfg.gain_cal_on, cfg.init_unlocked}, 2'h3)
        `CHK({cfg.lane_clock_config, cfg.averaging_setup}, 3'h5)
        `CHK({cfg.reference_disable, cfg.single_data_rate}, 2'h3)
        $display("register table test done");
        // Second enable alone, then a half key that must not unlock
        wr(8'h33, 16'h0040);
        idle();
        `CHK({cfg.gain_cal_on, cfg.init_unlocked}, 2'h2)
        wr(8'h33, 16'h0010);
        idle();
        `CHK({cfg.gain_cal_on, cfg.init_unlocked}, 2'h0)
        for (int i = 0; i < 4; i++) begin
            wr(8'hc0, 16'(i));
            idle();
            `CHK({cfg.chan_b_powered_down, cfg.chan_a_powered_down}, 2'(i))
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            pattern_select_chan_b <= 2'(i);
            #1;
            `CHK({pat_use_ramp, pat_alternate}, {1'(i == 2), 1'(i == 3)})
        end
        $display("field decode test done");
        // Reset in mid-run clears every register
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            rd(rows[i].a, q);
            `CHK(q, 16'h0000)
        end
        wr(8'h1a, 16'hbeef);
        wr(8'h55, 16'hffff);
        rd(8'h55, q);
        `CHK(q, 16'h0000)
        rd(8'h1a, q);
        `CHK(q, 16'hbeef)
        idle();
        $display("reset and unmapped test done");
        give_verdict();
    end
endmodule
